/* File: inc/uiw_regs.vh */
// register offsets, field positions and timing constants of the serial interrupt block
`ifndef UIW_REGS_VH
`define UIW_REGS_VH
// byte offsets on the axi4-lite port
`define UIW_OFF_CTRL2 8'h00
`define UIW_OFF_STATUS 8'h04
`define UIW_OFF_CORE 8'h08
`define UIW_OFF_EVENT 8'h0c
`define UIW_OFF_BUFFER 8'h10
// control word fields
`define UIW_C2_TEIE 0
`define UIW_C2_TIIE 1
`define UIW_C2_RX_IE 2
`define UIW_C2_ADDR_DET 3
`define UIW_C2_WAKE 4
`define UIW_C2_NINE_BIT 5
`define UIW_C2_PARITY 6
`define UIW_C2_UEN 7
`define UIW_C2_RX_EN 8
`define UIW_C2_SER_IE 9
`define UIW_C2_W 10
`define UIW_C2_RESET 10'h000
// core control fields
`define UIW_CORE_GIE 0
`define UIW_CORE_STACK_FULL 1
`define UIW_CORE_CLK_OFF 2
`define UIW_CORE_RESET 3'h0
// status fields
`define UIW_ST_TXE 0
`define UIW_ST_TIDLE 1
`define UIW_ST_RX_AVAIL 2
`define UIW_ST_OVERRUN 3
// recovery interval after wake in ns, and its cycle count at 5 ns
`define UIW_RECOVER_NS 1000
`define UIW_CLK_NS 5
`define UIW_RECOVER_CYC ((`UIW_RECOVER_NS + `UIW_CLK_NS - 1) / `UIW_CLK_NS)
`endif

/* File: logic/uiw_irq_wake.v */
// serial interrupt generation, address detect and pin wake-up logic
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "uiw_regs.vh"
module uiw_irq_wake #(
  parameter RECOVER_CYC = `UIW_RECOVER_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_empty_evt,
  input wire tx_idle_evt,
  input wire rx_word_evt,
  input wire [8:0] rx_word,
  input wire rx_trigger_evt,
  input wire overrun_evt,
  input wire serial_pin,
  output reg serial_irq_n,
  output reg wake_req,
  output reg rx_ignore,
  output reg module_run
);
  reg [`UIW_C2_W-1:0] serial_control_two;
  reg [2:0] core_ctrl_reg;
  reg [3:0] serial_status_reg;
  reg status_seen_reg;
  reg aw_got_reg, w_got_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg [3:0] addr_evt_cnt_reg;
  reg [15:0] recover_cnt_reg;
  reg wake_pend_reg;
  reg wake_clr_reg;
  reg irq_n_next;
  wire pin_sync;
  wire wake_caught;
  wire wake_none_s;
  wire wake_armed;
  wire rd_status;
  wire rd_buffer;
  wire top_bit;
  wire addr_hit;
  wire rx_data_req;
  wire gate;
  wire gie = core_ctrl_reg[`UIW_CORE_GIE];
  wire ser_ie = serial_control_two[`UIW_C2_SER_IE];
  wire rx_ie = serial_control_two[`UIW_C2_RX_IE];
  wire addr_det = serial_control_two[`UIW_C2_ADDR_DET];
  wire clk_off = core_ctrl_reg[`UIW_CORE_CLK_OFF];

  uiw_sync2 u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(serial_pin),
    .q(pin_sync)
  );

  // arm only while the module clock is off with all wake enables set
  assign wake_armed = clk_off & serial_control_two[`UIW_C2_WAKE] &
    serial_control_two[`UIW_C2_UEN] & serial_control_two[`UIW_C2_RX_EN] &
    rx_ie;

  uiw_wake_edge u_wake_edge (
    .pin_in(serial_pin),
    .arm(wake_armed),
    .clear(wake_clr_reg),
    .caught(wake_caught)
  );

  // carried inverted so the synchroniser's reset level means nothing caught
  uiw_sync2 u_wake_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(~wake_caught),
    .q(wake_none_s)
  );

  // axi4-lite write side: address and data taken in either order
  wire wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      serial_control_two <= `UIW_C2_RESET;
      core_ctrl_reg <= `UIW_CORE_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        case (aw_addr_reg)
          `UIW_OFF_CTRL2: begin
            if (w_strb_reg[0])
              serial_control_two[7:0] <= w_data_reg[7:0];
            if (w_strb_reg[1])
              serial_control_two[9:8] <= w_data_reg[9:8];
          end
          `UIW_OFF_CORE: begin
            if (w_strb_reg[0])
              core_ctrl_reg <= w_data_reg[2:0];
          end
          // status is read-only: writes are accepted and dropped
          `UIW_OFF_STATUS, `UIW_OFF_EVENT, `UIW_OFF_BUFFER: begin
            s_axi_bresp <= 2'h0;
          end
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read side, answer one cycle after the address is taken
  wire rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_status = rd_fire && (s_axi_araddr == `UIW_OFF_STATUS);
  assign rd_buffer = rd_fire && (s_axi_araddr == `UIW_OFF_BUFFER);
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `UIW_OFF_CTRL2: s_axi_rdata <= {22'h0, serial_control_two};
        `UIW_OFF_STATUS: s_axi_rdata <= {28'h0, serial_status_reg};
        `UIW_OFF_CORE: s_axi_rdata <= {29'h0, core_ctrl_reg};
        `UIW_OFF_EVENT: s_axi_rdata <= {12'h0, recover_cnt_reg,
          addr_evt_cnt_reg};
        `UIW_OFF_BUFFER: s_axi_rdata <= {23'h0, rx_word};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // address qualification of a received word
  assign top_bit = serial_control_two[`UIW_C2_NINE_BIT] ? rx_word[8] :
    rx_word[7];
  assign addr_hit = rx_word_evt & addr_det & top_bit;
  assign rx_data_req = rx_trigger_evt & (~addr_det | top_bit);
  assign gate = gie & ser_ie & ~core_ctrl_reg[`UIW_CORE_STACK_FULL];

  // status flags: hardware sets win over the buffer-read and access-sequence clears
  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_status_reg <= 4'h0;
      status_seen_reg <= 1'b0;
      addr_evt_cnt_reg <= 4'h0;
    end else begin
      if (rd_status)
        status_seen_reg <= 1'b1;
      else if (rd_buffer)
        status_seen_reg <= 1'b0;
      serial_status_reg[`UIW_ST_TXE] <= tx_empty_evt |
        (serial_status_reg[`UIW_ST_TXE] & ~rd_buffer);
      serial_status_reg[`UIW_ST_TIDLE] <= tx_idle_evt |
        (serial_status_reg[`UIW_ST_TIDLE] & ~rd_buffer);
      serial_status_reg[`UIW_ST_RX_AVAIL] <= rx_word_evt |
        (serial_status_reg[`UIW_ST_RX_AVAIL] &
        ~(rd_buffer & status_seen_reg));
      serial_status_reg[`UIW_ST_OVERRUN] <= overrun_evt |
        (serial_status_reg[`UIW_ST_OVERRUN] &
        ~(rd_buffer & status_seen_reg));
      if (addr_hit)
        addr_evt_cnt_reg <= addr_evt_cnt_reg + 4'h1;
    end
  end

  // wake sequence: caught edge, hold rx off, wait recovery, then interrupt
  always @(posedge aclk) begin
    if (!aresetn) begin
      wake_req <= 1'b0;
      wake_clr_reg <= 1'b1;
      wake_pend_reg <= 1'b0;
      recover_cnt_reg <= 16'h0000;
      rx_ignore <= 1'b0;
      module_run <= 1'b0;
    end else begin
      // tx and rx datapaths stall on this, keeping their state
      module_run <= ~clk_off;
      wake_clr_reg <= 1'b0;
      wake_pend_reg <= 1'b0;
      if (!wake_none_s && !wake_clr_reg && !rx_ignore) begin
        wake_req <= 1'b1;
        rx_ignore <= 1'b1;
        recover_cnt_reg <= RECOVER_CYC[15:0];
        wake_clr_reg <= 1'b1;
      end else if (rx_ignore) begin
        wake_req <= 1'b0;
        if (recover_cnt_reg == 16'h0001) begin
          rx_ignore <= 1'b0;
          wake_pend_reg <= 1'b1;
        end
        recover_cnt_reg <= recover_cnt_reg - 16'h0001;
      end
    end
  end

  // one low cycle for each cycle with a qualifying event
  always @* begin
    irq_n_next = 1'b1;
    if (gate && ((tx_empty_evt && serial_control_two[`UIW_C2_TEIE]) ||
        (tx_idle_evt && serial_control_two[`UIW_C2_TIIE]) ||
        (rx_ie && (rx_data_req || overrun_evt)) ||
        addr_hit || wake_pend_reg))
      irq_n_next = 1'b0;
  end

  always @(posedge aclk) begin
    if (!aresetn)
      serial_irq_n <= 1'b1;
    else
      serial_irq_n <= irq_n_next;
  end
endmodule // uiw_irq_wake

/* File: logic/uiw_sync2.v */
// two flip-flop synchroniser for one level
`timescale 1ns/10ps
module uiw_sync2 (
  input wire aclk,
  input wire aresetn,
  input wire d,
  output reg q
);
  reg meta_reg;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // uiw_sync2

/* File: logic/uiw_wake_edge.v */
// clockless falling-edge catcher on the serial pin, cleared from the clock domain
`timescale 1ns/10ps
module uiw_wake_edge (
  input wire pin_in,
  input wire arm,
  input wire clear,
  output reg caught
);
  // the pin itself clocks the catcher so it works with the module clock off
  always @(negedge pin_in or posedge clear) begin
    if (clear) begin
      caught <= 1'b0;
    end else if (arm) begin
      caught <= 1'b1;
    end
  end
endmodule // uiw_wake_edge

/* File: testbench/test_uiw_irq_wake.sv */
// self-checking bench for the serial interrupt and wake block
`timescale 1ns/10ps
`include "uiw_regs.vh"
module test_uiw_irq_wake;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, serial_pin, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_irq_n, wake_req, rx_ignore, module_run;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, irq_cnt, base, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [8:0] rx_word;
  logic [4:0] evs;
  wire tx_empty_evt, tx_idle_evt, rx_word_evt, rx_trigger_evt, overrun_evt;
  int bad_count, tests_run;
  assign {overrun_evt, rx_trigger_evt, rx_word_evt, tx_idle_evt,
    tx_empty_evt} = evs;
  // short recovery keeps the wake scenarios brief
  uiw_irq_wake #(.RECOVER_CYC(4)) i_dut (.*);
  uiw_host i_host (
    .aclk(aclk),
    .serial_irq_n(serial_irq_n),
    .irq_cnt(irq_cnt)
  );
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  task print_verdict;
    $display("mismatches %0d checks %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60) begin
      bad_count++;
      print_verdict;
    end
  endtask
  // local flags track each channel; the nets only update after the edge
  task wr(logic [7:0] a, logic [31:0] d);
    int n;
    bit aw_on, w_on, b_on;
    n = 0;
    aw_on = 1;
    w_on = 1;
    b_on = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (aw_on || w_on || b_on) begin
      tick(n);
      if (aw_on && s_axi_awready) begin
        aw_on = 0;
        s_axi_awvalid <= 0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 0;
        s_axi_wvalid <= 0;
      end
      if (b_on && s_axi_bvalid) begin
        b_on = 0;
        s_axi_bready <= 0;
      end
    end
    @(posedge aclk);
  endtask
  task rd(logic [7:0] a);
    int n;
    bit ar_on, r_on;
    n = 0;
    ar_on = 1;
    r_on = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (ar_on || r_on) begin
      tick(n);
      if (ar_on && s_axi_arready) begin
        ar_on = 0;
        s_axi_arvalid <= 0;
      end
      if (r_on && s_axi_rvalid) begin
        r_on = 0;
        s_axi_rready <= 0;
        rd_d = s_axi_rdata;
        r = s_axi_rresp;
      end
    end
    @(posedge aclk);
  endtask
  task fire(int k, int e);
    base = irq_cnt;
    evs <= 5'h01 << k;
    @(posedge aclk);
    evs <= 5'h00;
    repeat (2) @(posedge aclk);
    chk("irq pulses", e, irq_cnt - base);
  endtask
  task t_gate;
    logic [9:0] en [4];
    int src [4];
    en = '{10'h001, 10'h002, 10'h004, 10'h004};
    src = '{0, 1, 3, 4};
    wr(`UIW_OFF_CORE, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`UIW_OFF_CTRL2, 32'h200 | en[i]);
      fire(src[i], 1);
      wr(`UIW_OFF_CTRL2, 32'h207 & ~en[i]);
      fire(src[i], 0);
      wr(`UIW_OFF_CTRL2, 32'h007);
      fire(src[i], 0);
    end
    wr(`UIW_OFF_CTRL2, 32'h207);
    wr(`UIW_OFF_CORE, 32'h3);
    fire(0, 0);
    wr(`UIW_OFF_CORE, 32'h0);
    fire(0, 0);
    $display("gating test done");
  endtask
  task t_addr;
    wr(`UIW_OFF_CORE, 32'h1);
    for (int m = 0; m < 8; m++) begin
      wr(`UIW_OFF_CTRL2, 32'h204 | (m[2] << 3) | (m[1] << 5));
      // the unused top bit is set on purpose to catch a wrong select
      rx_word <= (m[0] == m[1]) ? 9'h100 : 9'h080;
      fire(3, !m[2] || m[0]);
    end
    wr(`UIW_OFF_CTRL2, 32'h22c);
    rx_word <= 9'h100;
    fire(2, 1);
    $display("address test done");
  endtask
  task t_flags;
    rd(`UIW_OFF_STATUS);
    rd(`UIW_OFF_BUFFER);
    rd(`UIW_OFF_STATUS);
    chk("status", 32'h0, rd_d);
    wr(`UIW_OFF_CTRL2, 32'h000);
    fire(4, 0);
    rd(`UIW_OFF_STATUS);
    chk("status", 32'h8, rd_d);
    wr(`UIW_OFF_STATUS, 32'h0);
    rd(`UIW_OFF_STATUS);
    chk("status", 32'h8, rd_d);
    rd(`UIW_OFF_BUFFER);
    chk("buffer", {23'h0, rx_word}, rd_d);
    rd(`UIW_OFF_STATUS);
    chk("status", 32'h0, rd_d);
    rd(8'h14);
    chk("rresp", 32'h2, r);
    $display("flag test done");
  endtask
  task t_wake(logic [31:0] core, int e);
    int n;
    n = 0;
    wr(`UIW_OFF_CTRL2, 32'h394);
    wr(`UIW_OFF_CORE, core);
    base = irq_cnt;
    serial_pin <= 0;
    while (!wake_req) tick(n);
    tick(n);
    tick(n);
    while (rx_ignore) tick(n);
    repeat (3) @(posedge aclk);
    chk("wake irq", e, irq_cnt - base);
    serial_pin <= 1;
    wr(`UIW_OFF_CORE, core & 32'h1);
    rd(`UIW_OFF_CTRL2);
    chk("ctrl2", 32'h394, rd_d);
    $display("wake test done");
  endtask
  initial begin
    aresetn = 0;
    evs = 0;
    rx_word = 0;
    serial_pin = 1;
    s_axi_awvalid = 0;
    s_axi_wvalid = 0;
    s_axi_bready = 0;
    s_axi_arvalid = 0;
    s_axi_rready = 0;
    s_axi_awaddr = 0;
    s_axi_araddr = 0;
    s_axi_wdata = 0;
    s_axi_wstrb = 4'hf;
    bad_count = 0;
    tests_run = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_gate;
    t_addr;
    t_flags;
    t_wake(32'h5, 1);
    t_wake(32'h4, 0);
    print_verdict;
  end
endmodule // test_uiw_irq_wake

/* File: testbench/uiw_host.sv */
// far-side model: interrupt controller counting request pulses
`timescale 1ns/10ps
module uiw_host (
  input wire logic aclk,
  input wire logic serial_irq_n,
  output logic [31:0] irq_cnt
);
  initial irq_cnt = 32'h0;
  // each sampled low cycle is one vectoring request
  always @(posedge aclk) begin
    if (!serial_irq_n)
      irq_cnt <= irq_cnt + 32'h1;
  end
endmodule // uiw_host

/* File: testbench/uiw_irq_wake_props.sv */
// assertions on the ports of the serial interrupt block
`timescale 1ns/10ps
module uiw_irq_wake_props #(
  parameter RECOVER_CYC = 200
) (
  input wire aclk,
  input wire aresetn,
  input wire tx_empty_evt,
  input wire tx_idle_evt,
  input wire rx_word_evt,
  input wire rx_trigger_evt,
  input wire overrun_evt,
  input wire serial_irq_n,
  input wire wake_req,
  input wire rx_ignore,
  input wire module_run
);
  int unsigned cnt;
  // counts sampled cycles of the recovery level
  always @(posedge aclk) begin
    if (!aresetn)
      cnt <= 0;
    else
      cnt <= rx_ignore ? cnt + 1 : 0;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_irq_one;
    $fell(serial_irq_n) |=> serial_irq_n;
  endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq low too long");
  property p_irq_cause;
    !serial_irq_n |-> $past(tx_empty_evt | tx_idle_evt | rx_word_evt |
      rx_trigger_evt | overrun_evt) || $past(rx_ignore, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
  property p_wake_one;
    wake_req |=> !wake_req;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake not a pulse");
  property p_wake_off;
    wake_req |-> !module_run;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake with clock");
  property p_wake_quiet;
    wake_req |-> ##[0:2] rx_ignore;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("no ignore");
  property p_recover;
    $fell(rx_ignore) |-> cnt == RECOVER_CYC;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery length");
  property p_quiet_irq;
    rx_ignore |-> serial_irq_n;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq) else $error("irq early");
  property p_ignore_min;
    $rose(rx_ignore) |-> rx_ignore[*4];
  endproperty
  a_ignore_min: assert property (p_ignore_min) else $error("ignore short");
endmodule // uiw_irq_wake_props
bind uiw_irq_wake uiw_irq_wake_props #(.RECOVER_CYC(RECOVER_CYC)) u_props (.*);
